/* hw/serx_pkg.sv */
package serx_pkg;
  // widths of the symbol path and of the parallel side, depth of the elastic buffer
  localparam int SYM_W = 10;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;

  // comma symbol in both running disparities, first bit in bit 9
  localparam logic [9:0] COMMA_NEG = 10'h0FA;
  localparam logic [9:0] COMMA_POS = 10'h305;

  // serial and parallel rates of the real link, kept for reference
  localparam int LINE_RATE_MBPS = 2500;
  localparam int PAR_CLOCK_MHZ = 250;

  // local clock and the launch clock made from it
  localparam int CLK_PERIOD_NS = 50;
  localparam int RX_SOURCE_CLOCK_PERIOD_NS = 400;
  localparam int RX_SOURCE_CLOCK_HALF_CYC = RX_SOURCE_CLOCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // bit count inside one symbol
  localparam logic [3:0] BIT_LAST = 4'h9;
  localparam logic [3:0] BIT_FIRST = 4'h0;

  typedef enum logic {SERX_HUNT, SERX_LOCKED} serx_align_e;
endpackage

/* hw/serx_fifo.sv */
module serx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  // pointer arithmetic wraps correctly only for power-of-two depths
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("serx_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;

  assign inReady = (wrPtr - rdPtr) != (AW + 1)'(DEPTH);
  assign outValid = wrPtr != rdPtr;
  assign outData = mem[rdPtr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (inValid && inReady) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (inValid && inReady) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (outValid && outReady) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end
endmodule

/* hw/serx_rx_path.sv */
// What this block does
// - controller inputs are sampled only on the controller's transmit clock
// - device drives its receive clock; bytes and status launch on it
// - parallel side carries 8-bit words each way at 250 MHz
// - serial link is one differential pair each way at 2.5 Gbit/s
// - carrier detect reports line presence to deserializer and coding logic
// - with a stream present, recover bit clock, then retime bits on it
// - retimed bits are grouped into 10-bit words, boundary arbitrary
// - search for the comma symbol and move the word boundary onto it
// - each aligned symbol decodes to a byte plus data/control flag
// - bytes cross an elastic buffer into the receive clock domain
// - symbol-type output low for data bytes, high for control symbols
// - receive-valid set on each launch edge only while locked and byte outputs carry valid data
// - line-idle output is unsynchronised; controller must synchronise it
module serx_rx_path #(
  parameter int RX_SOURCE_CLOCK_HALF = serx_pkg::RX_SOURCE_CLOCK_HALF_CYC,
  parameter int FIFO_DEPTH = serx_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial line side
  input wire logic rxSerialData,
  input wire logic rxBitClock,
  input wire logic rxCarrier,
  // controller inputs, timed by its clock
  input wire logic txSourceClock,
  input wire logic rxPolarity,
  // controller outputs, timed by our clock
  output logic rxSourceClock,
  output logic [serx_pkg::BYTE_W-1:0] rxByteOut,
  output logic rxSymbolIsControl,
  output logic rxLockValid,
  output logic rxLineIdle
);
  // divider counter is eight bits wide
  if (RX_SOURCE_CLOCK_HALF < 2 || RX_SOURCE_CLOCK_HALF > 256) begin : g_bad_half
    $error("serx_rx_path needs two to 256 cycles per clock half");
  end

  // 6b group to low five bits, 1 in bit 5 when not a code
  function automatic logic [5:0] dec6(input logic [5:0] c);
    case (c)
      6'h27, 6'h18: dec6 = 6'h00;
      6'h1D, 6'h22: dec6 = 6'h01;
      6'h2D, 6'h12: dec6 = 6'h02;
      6'h31: dec6 = 6'h03;
      6'h35, 6'h0A: dec6 = 6'h04;
      6'h29: dec6 = 6'h05;
      6'h19: dec6 = 6'h06;
      6'h38, 6'h07: dec6 = 6'h07;
      6'h39, 6'h06: dec6 = 6'h08;
      6'h25: dec6 = 6'h09;
      6'h15: dec6 = 6'h0A;
      6'h34: dec6 = 6'h0B;
      6'h0D: dec6 = 6'h0C;
      6'h2C: dec6 = 6'h0D;
      6'h1C: dec6 = 6'h0E;
      6'h17, 6'h28: dec6 = 6'h0F;
      6'h1B, 6'h24: dec6 = 6'h10;
      6'h23: dec6 = 6'h11;
      6'h13: dec6 = 6'h12;
      6'h32: dec6 = 6'h13;
      6'h0B: dec6 = 6'h14;
      6'h2A: dec6 = 6'h15;
      6'h1A: dec6 = 6'h16;
      6'h3A, 6'h05: dec6 = 6'h17;
      6'h33, 6'h0C: dec6 = 6'h18;
      6'h26: dec6 = 6'h19;
      6'h16: dec6 = 6'h1A;
      6'h36, 6'h09: dec6 = 6'h1B;
      6'h0E, 6'h0F, 6'h30: dec6 = 6'h1C;
      6'h2E, 6'h11: dec6 = 6'h1D;
      6'h1E, 6'h21: dec6 = 6'h1E;
      6'h2B, 6'h14: dec6 = 6'h1F;
      default: dec6 = 6'h20;
    endcase
  endfunction

  function automatic logic [2:0] dec4(input logic [3:0] c);
    case (c)
      4'hB, 4'h4: dec4 = 3'h0;
      4'h9: dec4 = 3'h1;
      4'h5: dec4 = 3'h2;
      4'hC, 4'h3: dec4 = 3'h3;
      4'hD, 4'h2: dec4 = 3'h4;
      4'hA: dec4 = 3'h5;
      4'h6: dec4 = 3'h6;
      default: dec4 = 3'h7;
    endcase
  endfunction

  // pin synchronisers; first stages feed only second stages
  logic dataS1, dataS2, bitClkS1, bitClkS2, bitClkPrev;
  logic carrS1, carrS2, txClkS1, txClkS2, txClkPrev;
  logic polS1, polS2;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dataS1 <= 1'b0;
      dataS2 <= 1'b0;
      bitClkS1 <= 1'b0;
      bitClkS2 <= 1'b0;
      bitClkPrev <= 1'b0;
      carrS1 <= 1'b0;
      carrS2 <= 1'b0;
      txClkS1 <= 1'b0;
      txClkS2 <= 1'b0;
      txClkPrev <= 1'b0;
      polS1 <= 1'b0;
      polS2 <= 1'b0;
    end else begin
      dataS1 <= rxSerialData;
      dataS2 <= dataS1;
      bitClkS1 <= rxBitClock;
      bitClkS2 <= bitClkS1;
      bitClkPrev <= bitClkS2;
      carrS1 <= rxCarrier;
      carrS2 <= carrS1;
      txClkS1 <= txSourceClock;
      txClkS2 <= txClkS1;
      txClkPrev <= txClkS2;
      polS1 <= rxPolarity;
      polS2 <= polS1;
    end
  end

  // polarity command taken only on a controller clock rising edge
  logic polInvert;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      polInvert <= 1'b0;
    end else if (txClkS2 && !txClkPrev) begin
      polInvert <= polS2;
    end
  end

  // recovered bit edge, gated by line presence
  logic bitTick;
  logic bitIn;
  assign bitTick = bitClkS2 && !bitClkPrev && carrS2;
  assign bitIn = dataS2 ^ polInvert;

  logic [serx_pkg::SYM_W-2:0] history;
  logic [serx_pkg::SYM_W-1:0] window;
  logic isComma;
  assign window = {history, bitIn};
  assign isComma = window == serx_pkg::COMMA_NEG ||
                   window == serx_pkg::COMMA_POS;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      history <= '0;
    end else if (bitTick) begin
      history <= window[serx_pkg::SYM_W-2:0];
    end
  end

  // alignment state and symbol boundary
  serx_pkg::serx_align_e align;
  logic [3:0] bitCnt;
  logic symDone;
  logic symValid;
  logic symInReady;
  assign symDone = bitTick && (isComma ||
                   (align == serx_pkg::SERX_LOCKED &&
                    bitCnt == serx_pkg::BIT_LAST));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      align <= serx_pkg::SERX_HUNT;
      bitCnt <= serx_pkg::BIT_FIRST;
    end else if (!carrS2) begin
      align <= serx_pkg::SERX_HUNT;
      bitCnt <= serx_pkg::BIT_FIRST;
    end else if (symValid && !symInReady) begin
      // buffer overrun loses a byte, so the stream is no longer trusted
      align <= serx_pkg::SERX_HUNT;
    end else if (symDone) begin
      align <= serx_pkg::SERX_LOCKED;
      bitCnt <= serx_pkg::BIT_FIRST;
    end else if (bitTick) begin
      case (align)
        serx_pkg::SERX_LOCKED: bitCnt <= bitCnt + 4'h1;
        serx_pkg::SERX_HUNT: bitCnt <= serx_pkg::BIT_FIRST;
        default: bitCnt <= serx_pkg::BIT_FIRST;
      endcase
    end
  end

  // decode of one aligned symbol
  logic [5:0] lowCode;
  logic [3:0] highBits;
  logic [serx_pkg::BYTE_W-1:0] symByte;
  logic symCtrl;
  assign lowCode = dec6(window[9:4]);
  // positive-disparity K28 flips the meaning of the 4b group
  assign highBits = (window[9:4] == 6'h30) ? ~window[3:0] : window[3:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      symValid <= 1'b0;
      symByte <= '0;
      symCtrl <= 1'b0;
    end else begin
      symValid <= symDone;
      if (symDone) begin
        symByte <= {dec4(highBits), lowCode[4:0]};
        symCtrl <= window[9:4] == 6'h0F || window[9:4] == 6'h30 ||
                   ((window[3:0] == 4'h7 || window[3:0] == 4'h8) &&
                    (lowCode == 6'h17 || lowCode == 6'h1B ||
                     lowCode == 6'h1D || lowCode == 6'h1E));
      end
    end
  end

  // receive launch clock made by division
  // launch marks the edge on which the launch clock falls
  logic [7:0] divCnt;
  logic launch;
  assign launch = divCnt == 8'(RX_SOURCE_CLOCK_HALF - 1) && rxSourceClock;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt <= '0;
      rxSourceClock <= 1'b0;
    end else if (divCnt == 8'(RX_SOURCE_CLOCK_HALF - 1)) begin
      divCnt <= '0;
      rxSourceClock <= !rxSourceClock;
    end else begin
      divCnt <= divCnt + 8'h01;
    end
  end

  // elastic buffer; drained one byte per launch edge
  logic fifoOutValid;
  logic [serx_pkg::BYTE_W:0] fifoOut;

  serx_fifo #(
    .WIDTH(serx_pkg::BYTE_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_serx_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(symValid),
    .inReady(symInReady),
    .inData({symCtrl, symByte}),
    .outValid(fifoOutValid),
    .outReady(launch),
    .outData(fifoOut)
  );

  // byte, flag and valid outputs change on the falling launch edge, centred for the controller
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxByteOut <= '0;
      rxSymbolIsControl <= 1'b0;
      rxLockValid <= 1'b0;
      rxLineIdle <= 1'b1;
    end else begin
      rxLineIdle <= !carrS2;
      if (launch) begin
        rxLockValid <= fifoOutValid &&
                       align == serx_pkg::SERX_LOCKED;
        if (fifoOutValid) begin
          rxByteOut <= fifoOut[serx_pkg::BYTE_W-1:0];
          rxSymbolIsControl <= fifoOut[serx_pkg::BYTE_W];
        end
      end
    end
  end
endmodule

/* bench/serx_rx_path_sva.sv */
module serx_rx_path_sva #(
  parameter int RX_SOURCE_CLOCK_HALF = 4,
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // line and controller inputs
  input wire logic rxSerialData,
  input wire logic rxBitClock,
  input wire logic rxCarrier,
  input wire logic txSourceClock,
  input wire logic rxPolarity,
  // controller outputs
  input wire logic rxSourceClock,
  input wire logic [serx_pkg::BYTE_W-1:0] rxByteOut,
  input wire logic rxSymbolIsControl,
  input wire logic rxLockValid,
  input wire logic rxLineIdle
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // repeat count holds only for the default half period of 4
  property p_src_half;
    $changed(rxSourceClock) |=>
      $stable(rxSourceClock)[*3] ##1 $changed(rxSourceClock);
  endproperty
  a_src_half: assert property (p_src_half)
    else $error("launch clock half period wrong");
  property p_launch;
    !$fell(rxSourceClock) |->
      $stable({rxLockValid, rxSymbolIsControl, rxByteOut});
  endproperty
  a_launch: assert property (p_launch)
    else $error("outputs changed off the launch edge");
  property p_valid_stands;
    $rose(rxLockValid) |-> rxLockValid[*8] ##1 !rxLockValid;
  endproperty
  a_valid_stands: assert property (p_valid_stands)
    else $error("valid byte not held one launch period");
  property p_idle_high;
    (!rxCarrier)[*5] |-> rxLineIdle;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("line idle missing without carrier");
  property p_idle_low;
    rxCarrier[*5] |-> !rxLineIdle;
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("line idle shown with carrier present");
  property p_lock_drop;
    (!rxCarrier)[*8] ##1 (!rxCarrier)[*5] |-> !rxLockValid;
  endproperty
  a_lock_drop: assert property (p_lock_drop)
    else $error("valid kept after stream loss");
  property p_ctrl_code;
    rxLockValid && rxSymbolIsControl |-> (rxByteOut[4:0] == 5'h1C) ||
      (rxByteOut inside {8'hF7, 8'hFB, 8'hFD, 8'hFE});
  endproperty
  a_ctrl_code: assert property (p_ctrl_code)
    else $error("control flag on a non-control byte");
  property p_fresh;
    $fell(rst) |-> (!rxLockValid)[*8];
  endproperty
  a_fresh: assert property (p_fresh)
    else $error("valid right after reset");
endmodule

bind serx_rx_path serx_rx_path_sva #(.RX_SOURCE_CLOCK_HALF(RX_SOURCE_CLOCK_HALF),
  .FIFO_DEPTH(FIFO_DEPTH)) u_serx_rx_path_sva (.clk(clk), .rst(rst),
  .rxSerialData(rxSerialData), .rxBitClock(rxBitClock),
  .rxCarrier(rxCarrier), .txSourceClock(txSourceClock),
  .rxPolarity(rxPolarity), .rxSourceClock(rxSourceClock),
  .rxByteOut(rxByteOut), .rxSymbolIsControl(rxSymbolIsControl),
  .rxLockValid(rxLockValid), .rxLineIdle(rxLineIdle));

/* bench/serx_line_model.sv */
module serx_line_model (
  // serial line
  output logic rxSerialData,
  output logic rxBitClock,
  output logic rxCarrier
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rxSerialData = 1'b0;
    rxBitClock = 1'b0;
    rxCarrier = 1'b0;
  end
  // bit clock only runs inside symbols; data held 200 ns each side
  task automatic send_sym(input logic [9:0] sym);
    for (int i = 9; i >= 0; i--) begin
      rxSerialData = sym[i];
      #200 rxBitClock = 1'b1;
      #200 rxBitClock = 1'b0;
    end
  endtask
  task automatic set_carrier(input logic on);
    rxCarrier = on;
    #400;
  endtask
  // a dead line keeps toggling so it never looks like held data
  always #400 if (!rxCarrier) rxSerialData = ~rxSerialData;
endmodule

/* bench/test_serx_rx_path.sv */
`define CHK(nm, exp, act) begin \
  n_compared++; \
  if ((act) !== (exp)) begin \
    n_fail++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, act); \
  end \
end
module test_serx_rx_path;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic txSourceClock = 1'b0;
  logic rxPolarity = 1'b0;
  logic rxSerialData, rxBitClock, rxCarrier;
  logic rxSourceClock, rxSymbolIsControl, rxLockValid, rxLineIdle;
  logic [serx_pkg::BYTE_W-1:0] rxByteOut;
  logic [8:0] got[$];
  // comma, D21.5, D10.2, comma: neutral data keeps disparity simple
  logic [9:0] sym[4] = '{serx_pkg::COMMA_NEG, 10'h2AA, 10'h155,
    serx_pkg::COMMA_POS};
  logic [8:0] want[4] = '{9'h1BC, 9'h0B5, 9'h04A, 9'h1BC};
  int n_fail = 0;
  int n_compared = 0;

  serx_rx_path u_serx_rx_path (.clk(clk), .rst(rst),
    .rxSerialData(rxSerialData), .rxBitClock(rxBitClock),
    .rxCarrier(rxCarrier), .txSourceClock(txSourceClock),
    .rxPolarity(rxPolarity), .rxSourceClock(rxSourceClock),
    .rxByteOut(rxByteOut), .rxSymbolIsControl(rxSymbolIsControl),
    .rxLockValid(rxLockValid), .rxLineIdle(rxLineIdle));
  serx_line_model u_serx_line_model (.rxSerialData(rxSerialData),
    .rxBitClock(rxBitClock), .rxCarrier(rxCarrier));

  always #25 clk = ~clk;
  // controller samples on the rising launch clock
  always @(posedge rxSourceClock) begin
    if (rxLockValid === 1'b1) got.push_back({rxSymbolIsControl, rxByteOut});
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic set_pol(input logic v);
    wait_clk(1);
    rxPolarity = v;
    wait_clk(1);
    txSourceClock = 1'b1;
    wait_clk(2);
    txSourceClock = 1'b0;
  endtask
  task automatic t_reset;
    `CHK("idle", 1'b1, rxLineIdle)
    `CHK("valid", 1'b0, rxLockValid)
  endtask
  task automatic t_no_comma;
    u_serx_line_model.set_carrier(1'b1);
    got.delete();
    repeat (2) u_serx_line_model.send_sym(10'h2AA);
    wait_clk(40);
    `CHK("bytes", 0, got.size())
    `CHK("idle", 1'b0, rxLineIdle)
  endtask
  task automatic t_stream(input logic pol);
    set_pol(pol);
    got.delete();
    for (int i = 0; i < 4; i++) u_serx_line_model.send_sym(sym[i] ^ {10{pol}});
    wait_clk(40);
    `CHK("count", 4, got.size())
    for (int i = 0; i < 4; i++) `CHK("byte", want[i], got[i])
  endtask
  task automatic t_loss;
    u_serx_line_model.set_carrier(1'b0);
    wait_clk(20);
    `CHK("idle", 1'b1, rxLineIdle)
    `CHK("valid", 1'b0, rxLockValid)
    t_no_comma();
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    wait_clk(3);
    rst = 1'b0;
    wait_clk(5);
    t_reset();
    t_no_comma();
    t_stream(1'b0);
    t_stream(1'b1);
    t_loss();
    t_stream(1'b0);
    tally_and_finish();
  end
  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
endmodule
